// ===== rtl/aac_ctl_if.sv
// Interface that carries divider and window comparator signals inside the block.
`timescale 1ns/1ps
`default_nettype none
interface aac_ctl_if;
  logic run;
  logic [2:0] div_code;
  logic tick;
  logic [2:0] win_mode;
  logic [15:0] value;
  logic [15:0] low;
  logic [15:0] high;
  logic match;
  modport core (output run, div_code, win_mode, value, low, high, input tick, match);
  modport div (input run, div_code, output tick);
  modport cmp (input win_mode, value, low, high, output match);
endinterface
`default_nettype wire

// ===== rtl/aac_divider.sv
// Converter clock divider that yields a one-cycle tick per converter clock period.
`timescale 1ns/1ps
`default_nettype none
module aac_divider (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  aac_ctl_if.div ctl
);
  logic [7:0] cnt_q;
  logic [7:0] last;

  // Code n divides by 2 to the power n+1, so code 7 gives 256 (see RULE_11).
  // The shift amount is widened first; a 3-bit sum would wrap code 7 back to divide by 1.
  assign last = 8'(({1'b0, 8'h01} << (4'(ctl.div_code) + 4'h1)) - 9'h001);
  assign ctl.tick = ctl.run && (cnt_q == last);

  // The count restarts whenever the converter stops, so the first tick is a full period late.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !ctl.run || cnt_q >= last) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/aac_pkg.sv
// Shared constants for the converter control block: offsets, fields, resets and timing.
// -----------------------------------------------------------------------------
// Contract
// RULE_01: With resolution choice clear, the full 10-bit sample is summed or stored.
// RULE_02: With resolution choice set, the two lowest sample bits are dropped first.
// RULE_03: In continuous mode a trigger write starts the first conversion, then each restarts.
// RULE_04: Each finished conversion sets the result ready flag.
// RULE_05: Bit 0 of the main control register enables the converter.
// RULE_06: Bit 7 of the main control register lets the converter run in standby.
// RULE_07: Accumulate count code 0 means none, 1 to 6 mean 2 to 64 samples, 7 is reserved.
// RULE_08: A nonzero accumulate count sums that many samples into one result.
// RULE_09: The sampling capacitor bit picks full (0) or reduced (1) capacitance.
// RULE_10: The reference field picks internal (0) or supply (1); other codes are reserved.
// RULE_11: The clock divider code divides the peripheral clock by 2 up to 256.
// RULE_12: Writing 1 to the trigger bit starts a conversion; it reads 1 while busy.
// RULE_13: The window mode compares the 16-bit result with the low and high thresholds.
// RULE_14: The window match flag clears on a write of 1 or on a read of the result.
// RULE_15: Reserved bits and addresses ignore writes and read as zero.
// RULE_16: 16-bit registers place bits 7:0 low and bits 15:8 at the next offset.
// -----------------------------------------------------------------------------
package aac_pkg;

  // Register indexes; the bus byte address is four times the index.
  localparam logic [4:0] IDX_MAIN = 5'h00;
  localparam logic [4:0] IDX_ACC = 5'h01;
  localparam logic [4:0] IDX_REFPRE = 5'h02;
  localparam logic [4:0] IDX_TIMING = 5'h03;
  localparam logic [4:0] IDX_WINMODE = 5'h04;
  localparam logic [4:0] IDX_SAMPLEN = 5'h05;
  localparam logic [4:0] IDX_CHAN = 5'h06;
  localparam logic [4:0] IDX_CMD = 5'h08;
  localparam logic [4:0] IDX_TRIG = 5'h09;
  localparam logic [4:0] IDX_IRQEN = 5'h0a;
  localparam logic [4:0] IDX_FLAGS = 5'h0b;
  localparam logic [4:0] IDX_HALT = 5'h0c;
  localparam logic [4:0] IDX_SCRATCH = 5'h0d;
  localparam logic [4:0] IDX_RES_LO = 5'h10;
  localparam logic [4:0] IDX_RES_HI = 5'h11;
  localparam logic [4:0] IDX_WLT_LO = 5'h12;
  localparam logic [4:0] IDX_WLT_HI = 5'h13;
  localparam logic [4:0] IDX_WHT_LO = 5'h14;
  localparam logic [4:0] IDX_WHT_HI = 5'h15;
  localparam logic [4:0] IDX_TRIM = 5'h16;
  localparam int NUM_IDX = 24;

  // Field positions.
  localparam int MAIN_ENABLE = 0;
  localparam int MAIN_CONT = 1;
  localparam int MAIN_RES8 = 2;
  localparam int MAIN_STBY = 7;
  localparam int REFPRE_CAP = 6;
  localparam int REFPRE_REF_LSB = 4;
  localparam int FLAG_RDY = 0;
  localparam int FLAG_WIN = 1;

  // Writable bits per stored register; all other bits are reserved.
  localparam logic [7:0] MASK_MAIN = 8'h87;
  localparam logic [7:0] MASK_LOW3 = 8'h07;
  localparam logic [7:0] MASK_REFPRE = 8'h77;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_LOW5 = 8'h1f;
  localparam logic [7:0] MASK_BIT0 = 8'h01;
  localparam logic [7:0] MASK_LOW2 = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Accumulate and window codes.
  localparam logic [2:0] ACC_RESERVED = 3'h7;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // Converter clock cycles spent on one sample, sampling plus approximation.
  localparam int CONV_TICKS = 13;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } aac_state_t;

endpackage

// ===== rtl/aac_top.sv
// Converter control block: register file, conversion sequencer, accumulator and flags.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module aac_top #(
  parameter int CONV_TICKS_P = aac_pkg::CONV_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Avalon-MM slave, byte address, register data in the low byte.
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Chip state and trigger event.
  input wire logic standby_i,
  input wire logic halted_i,
  input wire logic event_i,
  // Analog front end.
  input wire logic [9:0] sample_data_i,
  output logic sample_take_o,
  output logic conv_active_o,
  output logic sampling_cap_o,
  output logic [1:0] reference_o,
  output logic [4:0] channel_o,
  output logic [7:0] timing_o,
  output logic [4:0] sample_len_o,
  output logic duty_trim_o,
  // Result ready event and interrupt.
  output logic result_event_o,
  output logic irq_o
);
  import aac_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (CONV_TICKS_P < 1 || CONV_TICKS_P > 255) begin : g_bad_ticks
    $error("CONV_TICKS_P must lie between 1 and 255.");
  end

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  aac_ctl_if ctl ();

  logic [7:0] reg_q [NUM_IDX];
  logic wait_q;
  logic [31:0] rdata_q;
  logic [4:0] idx;
  logic mapped;
  logic req;
  logic wr_take;
  logic rd_take;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] main_r;
  logic [7:0] acc_r;
  logic [7:0] refpre_r;
  logic enable;
  logic run;
  logic start_sw;
  logic start_ev;
  logic ev_q;
  aac_state_t state_q;
  logic [7:0] tick_cnt_q;
  logic [6:0] samp_cnt_q;
  logic [6:0] samp_goal;
  logic [15:0] acc_q;
  logic [15:0] sample_ext;
  logic [15:0] sum;
  logic sample_now;
  logic last_sample;
  logic done;
  logic [15:0] result_q;
  logic [1:0] flags_q;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic res_read;
  logic [7:0] ticks_last;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Byte addresses not on a word boundary, or beyond the map, are unmapped.
  assign idx = avs_address_i[6:2];
  assign mapped = (avs_address_i[1:0] == 2'b00) && (32'(idx) < NUM_IDX);
  assign req = avs_read_i || avs_write_i;

  // A request is answered on the second edge: the first edge loads read data and
  // drops waitrequest, the second edge is where the master sees it low and where
  // writes and read side effects act.
  assign wr_take = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign rd_take = avs_read_i && !wait_q;
  assign wbyte = avs_writedata_i[7:0];

  // Waitrequest is low for exactly one cycle per request.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  // Read data is captured one edge ahead so it stands at the taking edge.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= {24'h00_0000, rbyte};
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  // Live state is shown for the trigger, flags and result; others read stored bytes.
  always_comb begin
    rbyte = 8'h00; // Unmapped and reserved read as zero (see RULE_15).
    if (mapped) begin
      case (idx)
        IDX_CMD: rbyte = {7'h00, state_q == ST_CONV}; // see RULE_12
        IDX_FLAGS: rbyte = {6'h00, flags_q};
        IDX_RES_LO: rbyte = result_q[7:0]; // see RULE_16
        IDX_RES_HI: rbyte = result_q[15:8]; // see RULE_16
        default: rbyte = reg_q[idx];
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Stored registers
  // ---------------------------------------------------------------------------
  // Writable bits of each stored byte; zero marks a reserved bit or address, or a register read live.
  function automatic logic [7:0] wmask(input logic [4:0] i);
    case (i)
      IDX_MAIN: wmask = MASK_MAIN;
      IDX_ACC: wmask = MASK_LOW3;
      IDX_REFPRE: wmask = MASK_REFPRE;
      IDX_TIMING: wmask = MASK_FULL;
      IDX_WINMODE: wmask = MASK_LOW3;
      IDX_SAMPLEN: wmask = MASK_LOW5;
      IDX_CHAN: wmask = MASK_LOW5;
      IDX_TRIG: wmask = MASK_BIT0;
      IDX_IRQEN: wmask = MASK_LOW2;
      IDX_HALT: wmask = MASK_BIT0;
      IDX_SCRATCH: wmask = MASK_FULL;
      IDX_WLT_LO: wmask = MASK_FULL;
      IDX_WLT_HI: wmask = MASK_FULL;
      IDX_WHT_LO: wmask = MASK_FULL;
      IDX_WHT_HI: wmask = MASK_FULL;
      IDX_TRIM: wmask = MASK_BIT0;
      default: wmask = 8'h00;
    endcase
  endfunction

  // One byte per index, masked so reserved bits never change (see RULE_15).
  for (genvar g = 0; g < NUM_IDX; g++) begin : g_reg
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        reg_q[g] <= RESET_BYTE;
      end else if (wr_take && mapped && idx == 5'(g)) begin
        reg_q[g] <= wbyte & wmask(5'(g));
      end
    end
  end

  assign main_r = reg_q[IDX_MAIN];
  assign acc_r = reg_q[IDX_ACC];
  assign refpre_r = reg_q[IDX_REFPRE];

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  // Enable gates the sequencer and divider; standby and halt stop the divider unless allowed.
  assign enable = main_r[MAIN_ENABLE]; // see RULE_05
  assign run = enable && (!standby_i || main_r[MAIN_STBY]) // see RULE_06
               && (!halted_i || reg_q[IDX_HALT][0]);

  assign start_sw = wr_take && mapped && idx == IDX_CMD && wbyte[0]; // see RULE_12
  assign start_ev = reg_q[IDX_TRIG][0] && event_i && !ev_q;

  // Event input is taken on its rising edge only.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ev_q <= 1'b0;
    end else begin
      ev_q <= event_i;
    end
  end

  assign ctl.run = run && state_q == ST_CONV;
  assign ctl.div_code = refpre_r[2:0]; // see RULE_11

  aac_divider u_div (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ctl(ctl)
  );

  // ---------------------------------------------------------------------------
  // Sample counting
  // ---------------------------------------------------------------------------
  // Reserved count 7 is served as no accumulation (see RULE_07).
  assign samp_goal = (acc_r[2:0] == ACC_RESERVED) ? 7'h01 : 7'(8'h01 << acc_r[2:0]);
  assign ticks_last = 8'(CONV_TICKS_P - 1);
  assign sample_now = ctl.tick && tick_cnt_q == ticks_last;
  assign last_sample = samp_cnt_q == 7'(samp_goal - 7'h01);
  assign done = sample_now && last_sample;

  // Truncated samples lose their two lowest bits (see RULE_01) (see RULE_02).
  assign sample_ext = main_r[MAIN_RES8] ? {8'h00, sample_data_i[9:2]}
                                        : {6'h00, sample_data_i};
  assign sum = acc_q + sample_ext; // 64 full samples fit in 16 bits.

  // Converter clock ticks within one sample.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || state_q != ST_CONV) begin
      tick_cnt_q <= 8'h00;
    end else if (sample_now) begin
      tick_cnt_q <= 8'h00;
    end else if (ctl.tick) begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // Samples taken so far and their running sum (see RULE_08).
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || state_q != ST_CONV || done) begin
      samp_cnt_q <= 7'h00;
      acc_q <= 16'h0000;
    end else if (sample_now) begin
      samp_cnt_q <= samp_cnt_q + 7'h01;
      acc_q <= sum;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Continuous mode restarts at once; disabling aborts without a result.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !enable) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_sw || start_ev) begin
            state_q <= ST_CONV; // see RULE_12
          end
        end
        ST_CONV: begin
          if (done && !main_r[MAIN_CONT]) begin
            state_q <= ST_IDLE; // see RULE_03
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // The finished sum becomes the visible result.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_q <= 16'h0000;
    end else if (done) begin
      result_q <= sum;
    end
  end

  // ---------------------------------------------------------------------------
  // Window comparator
  // ---------------------------------------------------------------------------
  assign ctl.win_mode = reg_q[IDX_WINMODE][2:0];
  assign ctl.value = sum;
  assign ctl.low = {reg_q[IDX_WLT_HI], reg_q[IDX_WLT_LO]}; // see RULE_16
  assign ctl.high = {reg_q[IDX_WHT_HI], reg_q[IDX_WHT_LO]}; // see RULE_16

  // Compared only on the last sample, so an accumulation flags once (see RULE_13).
  aac_window u_win (
    .ctl(ctl)
  );

  // ---------------------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------------------
  assign res_read = rd_take && mapped && (idx == IDX_RES_LO || idx == IDX_RES_HI);
  assign flag_set = {done && ctl.match, done}; // see RULE_04

  // Flags clear on a read of themselves, on writing 1, and the result read clears
  // both; a new event in the same cycle wins over any clear (see RULE_14).
  always_comb begin
    flag_clr = 2'b00;
    if (mapped && idx == IDX_FLAGS) begin
      if (rd_take) begin
        flag_clr = 2'b11;
      end
      if (wr_take) begin
        flag_clr = flag_clr | wbyte[1:0];
      end
    end
    if (res_read) begin
      flag_clr = 2'b11;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flags_q <= 2'b00;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Interrupt is a level held while any unmasked flag stands.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((flags_q & ~flag_clr) | flag_set) & reg_q[IDX_IRQEN][1:0]);
    end
  end

  // Result event is a one-cycle pulse per finished conversion.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_event_o <= 1'b0;
    end else begin
      result_event_o <= done;
    end
  end

  // ---------------------------------------------------------------------------
  // Front-end outputs
  // ---------------------------------------------------------------------------
  // Registered copies keep glitches off the analog controls.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sample_take_o <= 1'b0;
      conv_active_o <= 1'b0;
      sampling_cap_o <= 1'b0;
      reference_o <= 2'b00;
      channel_o <= 5'h00;
      timing_o <= 8'h00;
      sample_len_o <= 5'h00;
      duty_trim_o <= 1'b0;
    end else begin
      sample_take_o <= sample_now;
      conv_active_o <= state_q == ST_CONV;
      sampling_cap_o <= refpre_r[REFPRE_CAP]; // see RULE_09
      reference_o <= refpre_r[REFPRE_REF_LSB +: 2]; // see RULE_10
      channel_o <= reg_q[IDX_CHAN][4:0];
      timing_o <= reg_q[IDX_TIMING];
      sample_len_o <= reg_q[IDX_SAMPLEN][4:0];
      duty_trim_o <= reg_q[IDX_TRIM][0];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/aac_window.sv
// Window comparator on the finished 16-bit result.
`timescale 1ns/1ps
`default_nettype none
module aac_window (
  aac_ctl_if.cmp ctl
);
  import aac_pkg::*;

  // Reserved and zero codes never match (see RULE_13).
  always_comb begin
    case (ctl.win_mode)
      WIN_BELOW: ctl.match = ctl.value < ctl.low;
      WIN_ABOVE: ctl.match = ctl.value > ctl.high;
      WIN_INSIDE: ctl.match = (ctl.value > ctl.low) && (ctl.value < ctl.high);
      WIN_OUTSIDE: ctl.match = (ctl.value < ctl.low) || (ctl.value > ctl.high);
      default: ctl.match = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== verif/aac_top_monitor.sv
// Port-level concurrent checks for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module aac_top_monitor #(
  parameter int CONV_TICKS_P = 13
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sample_take_o,
  input wire logic conv_active_o,
  input wire logic sampling_cap_o,
  input wire logic [1:0] reference_o,
  input wire logic result_event_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Access accepted where waitrequest is low.
  logic acc_w;
  logic wr_w;
  assign acc_w = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_w = acc_w && avs_write_i && avs_byteenable_i[0];

  // ---------------------------------------------------------------------------
  // Bus checks
  // ---------------------------------------------------------------------------
  wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("Wait request stayed low too long.");
  wait_answer_a: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("Request not answered in one cycle.");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("Waitrequest low while idle.");
  high_zero_a: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("Upper read data nonzero.");
  unmapped_a: assert property (acc_w && avs_read_i && avs_address_i == 7'h1c
    |-> avs_readdata_o[7:0] == 8'h00)
    else $error("Reserved address read nonzero.");

  // ---------------------------------------------------------------------------
  // Converter checks
  // ---------------------------------------------------------------------------
  disable_stop_a: assert property (wr_w && avs_address_i == 7'h00 && !avs_writedata_i[0]
    |-> ##[1:3] !conv_active_o)
    else $error("Still busy after disable.");
  sample_busy_a: assert property (sample_take_o |-> conv_active_o)
    else $error("Sample taken while idle.");
  cfg_copy_a: assert property (wr_w && avs_address_i == 7'h08 |-> ##2
    (sampling_cap_o == $past(avs_writedata_i[6], 2)
    && reference_o == $past(avs_writedata_i[5:4], 2)))
    else $error("Cap or reference copy wrong.");
  res_clear_a: assert property (acc_w && avs_read_i && avs_address_i == 7'h40
    && !result_event_o |-> ##[1:2] !irq_o)
    else $error("Result read left irq high.");
  evt_pulse_a: assert property (result_event_o |=> !result_event_o)
    else $error("Result event too long.");

  // Main scenarios reached.
  done_c: cover property (result_event_o);
  irq_c: cover property ($rose(irq_o));
  sample_c: cover property (sample_take_o);
endmodule

bind aac_top aac_top_monitor #(.CONV_TICKS_P(CONV_TICKS_P)) u_monitor (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .sample_take_o(sample_take_o),
  .conv_active_o(conv_active_o),
  .sampling_cap_o(sampling_cap_o),
  .reference_o(reference_o),
  .result_event_o(result_event_o),
  .irq_o(irq_o)
);
`default_nettype wire

// ===== verif/tb_aac_top.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_aac_top;
  import aac_pkg::*;
  // Short sample time keeps the slow divider case brief.
  localparam int TICKS = 2;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [6:0] avs_address_i = 7'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic standby_i = 1'b0;
  logic halted_i = 1'b0;
  logic event_i = 1'b0;
  logic [9:0] sample_data_i = 10'h000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, conv_active_o, sampling_cap_o, result_event_o, irq_o;
  logic [1:0] reference_o;
  logic [7:0] rdat;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int cyc;

  aac_top #(.CONV_TICKS_P(TICKS)) dut (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .standby_i(standby_i),
    .halted_i(halted_i),
    .event_i(event_i),
    .sample_data_i(sample_data_i),
    .sample_take_o(),
    .conv_active_o(conv_active_o),
    .sampling_cap_o(sampling_cap_o),
    .reference_o(reference_o),
    .channel_o(),
    .timing_o(),
    .sample_len_o(),
    .duty_trim_o(),
    .result_event_o(result_event_o),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------------
  always #4 sys_clk_i = ~sys_clk_i;

  // Ceiling well above the run's length.
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One access, held until waitrequest is seen low at an edge; data taken there.
  task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h0, d};
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [7:0] e, input string what);
    bus(1'b0, idx, 8'h00);
    chk(what, {8'h00, e}, {8'h00, rdat});
  endtask

  // Waits for the result event, then one edge more; a hang meets the ceiling.
  task automatic wait_done(output int c);
    c = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      c++;
    end while (result_event_o !== 1'b1);
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic pause();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic conv(input logic [7:0] m, input logic [2:0] a, input logic [9:0] s,
                      input logic [15:0] e);
    wr(IDX_MAIN, m);
    sample_data_i <= s;
    wr(IDX_ACC, {5'h00, a});
    wr(IDX_CMD, 8'h01);
    wait_done(cyc);
    rd(IDX_RES_LO, e[7:0], "result low");
    rd(IDX_RES_HI, e[15:8], "result high");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(IDX_MAIN, 8'h00, "main reset");
    rd(IDX_ACC, 8'h00, "accumulate reset");
    rd(IDX_REFPRE, 8'h00, "reference reset");
    wr(IDX_MAIN, 8'hff);
    rd(IDX_MAIN, 8'h87, "main reserved bits");
    wr(5'h07, 8'ha5);
    rd(5'h07, 8'h00, "reserved address");
    // Slowest divider: reduced capacitor, supply reference, divide by 256.
    wr(IDX_REFPRE, 8'h57);
    wr(IDX_MAIN, 8'h01);
    wr(IDX_CMD, 8'h01);
    rd(IDX_CMD, 8'h01, "trigger busy");
    wait_done(cyc);
    chk("slow duration", 16'h1, {15'h0, cyc >= 256 * (TICKS - 1) && cyc <= 256 * (TICKS + 1)});
    rd(IDX_CMD, 8'h00, "trigger idle");
    chk("capacitor", 16'h1, {15'h0, sampling_cap_o});
    chk("reference", 16'h1, {14'h0, reference_o});
    wr(IDX_REFPRE, 8'h50);
    // Codes 0 and 7 give one sample.
    for (int k = 0; k < 8; k++) begin
      conv(8'h01, 3'(k), 10'h3ff, (k == 0 || k == 7) ? 16'h03ff : 16'h03ff << k);
    end
    conv(8'h05, 3'h2, 10'h2a5, 16'h02a4);
    conv(8'h05, 3'h0, 10'h2a5, 16'h00a9);
    // Event input start.
    wr(IDX_ACC, 8'h00);
    wr(IDX_TRIG, 8'h01);
    event_i <= 1'b1;
    wait_done(cyc);
    @(posedge sys_clk_i);
    event_i <= 1'b0;
    wr(IDX_TRIG, 8'h00);
    // Continuous mode restarts alone.
    wr(IDX_MAIN, 8'h03);
    wr(IDX_CMD, 8'h01);
    wait_done(cyc);
    wait_done(cyc);
    chk("continuous restart", 16'h1, {15'h0, cyc <= 40});
    wr(IDX_MAIN, 8'h00);
    wr(IDX_CMD, 8'h01);
    rd(IDX_CMD, 8'h00, "trigger while disabled");
    rd(IDX_FLAGS, 8'h01, "ready flag");
    // Standby freezes the converter unless standby_run is set.
    standby_i <= 1'b1;
    wr(IDX_MAIN, 8'h01);
    wr(IDX_CMD, 8'h01);
    repeat (100) @(posedge sys_clk_i);
    rd(IDX_FLAGS, 8'h00, "standby frozen");
    wr(IDX_MAIN, 8'h81);
    wait_done(cyc);
    @(posedge sys_clk_i);
    standby_i <= 1'b0;
    rd(IDX_RES_LO, 8'ha5, "standby result");
    // Window between 0x0080 and 0x0400 with a result of 0x0100.
    wr(IDX_MAIN, 8'h01);
    sample_data_i <= 10'h100;
    wr(IDX_WLT_LO, 8'h80);
    wr(IDX_WHT_HI, 8'h04);
    rd(IDX_WHT_HI, 8'h04, "high threshold upper byte");
    wr(IDX_IRQEN, 8'h02);
    for (int m = 0; m < 5; m++) begin
      wr(IDX_WINMODE, 8'(m));
      wr(IDX_CMD, 8'h01);
      wait_done(cyc);
      chk("window irq", {15'h0, m == 3}, {15'h0, irq_o});
      rd(IDX_RES_LO, 8'h00, "result low");
      pause();
      chk("irq after result read", 16'h0, {15'h0, irq_o});
    end
    // Mask, write of zero, then write of one to the match flag.
    wr(IDX_WINMODE, 8'h03);
    wr(IDX_CMD, 8'h01);
    wait_done(cyc);
    wr(IDX_IRQEN, 8'h00);
    pause();
    chk("irq masked", 16'h0, {15'h0, irq_o});
    wr(IDX_IRQEN, 8'h02);
    wr(IDX_FLAGS, 8'h00);
    pause();
    chk("irq after zero write", 16'h1, {15'h0, irq_o});
    wr(IDX_FLAGS, 8'h02);
    pause();
    chk("irq after flag clear", 16'h0, {15'h0, irq_o});
    summarize();
  end
endmodule
`default_nettype wire
